// file: src/cdgc_pkg.sv
package cdgc_pkg;

	// ****************************************************************
	// register map: indices, byte address is four times the index
	// ****************************************************************
	localparam logic [7:0]  CDGC_IDX_PATTERN = 8'h1A;
	localparam logic [7:0]  CDGC_IDX_CLKDIV  = 8'h1B;
	localparam logic [7:0]  CDGC_IDX_STATUS  = 8'h30;
	localparam logic [9:0]  CDGC_ADDR_PATTERN = {CDGC_IDX_PATTERN, 2'b00};
	localparam logic [9:0]  CDGC_ADDR_CLKDIV  = {CDGC_IDX_CLKDIV, 2'b00};
	localparam logic [9:0]  CDGC_ADDR_STATUS  = {CDGC_IDX_STATUS, 2'b00};
	localparam int          CDGC_ADDR_W       = 10;

	// ****************************************************************
	// clock divider configuration fields
	// ****************************************************************
	localparam int          CDGC_HBE_BIT   = 12;
	localparam int          CDGC_MFE_BIT   = 11;
	localparam int          CDGC_SGE_BIT   = 10;
	localparam int          CDGC_CAL_BIT   = 9;
	localparam int          CDGC_SEL_LSB   = 7;
	localparam int          CDGC_MOD_LSB   = 4;
	localparam int          CDGC_GEN_LSB   = 0;
	localparam int          CDGC_REG_W     = 16;
	localparam logic [15:0] CDGC_CFG_WMASK = 16'h1FFF;
	localparam logic [15:0] CDGC_CFG_RESET = 16'h0000;

	// ****************************************************************
	// status register fields
	// ****************************************************************
	localparam int          CDGC_ST_BUSY_BIT = 0;
	localparam int          CDGC_ST_SINC_LSB = 4;

	// ****************************************************************
	// generator and divider sizes
	// ****************************************************************
	localparam int          CDGC_CHANNELS  = 4;
	localparam int          CDGC_PAT_W     = 64;
	localparam int          CDGC_PAT_STEP  = 16;
	localparam int          CDGC_DIV_W     = 4;
	localparam logic [3:0]  CDGC_DIV_BYPASS = 4'h0;
	localparam logic [3:0]  CDGC_DIV_TOP    = 4'hF;
	localparam logic [3:0]  CDGC_DIV_CLAMP  = 4'hE;

	// ****************************************************************
	// bus encodings
	// ****************************************************************
	localparam logic [1:0]  CDGC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  CDGC_HTRANS_SEQ    = 2'h3;
	localparam logic [2:0]  CDGC_HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic       high_drive;
		logic       master_gate;
		logic       gen_enable;
		logic [1:0] channel;
		logic [2:0] mod_div;
		logic [3:0] gen_div;
	} cdgc_cfg_t;

	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [CDGC_ADDR_W-1:0] addr;
	} cdgc_xfer_t;

endpackage : cdgc_pkg

// file: src/cdgc_divider.sv
`timescale 1ns/1ps
`default_nettype none

module cdgc_divider
	import cdgc_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic [CDGC_DIV_W-1:0] div_code,
	output var  logic                  tick
);

	// ****************************************************************
	// ratio decode
	// ****************************************************************
	logic [CDGC_DIV_W-1:0] cnt_reg;
	logic [CDGC_DIV_W-1:0] cnt_next;
	logic [CDGC_DIV_W-1:0] last_count;
	logic                  wrap;

	// bypass: every cycle is a tick
	// top code clamps to the ratio of the code below it
	assign last_count = (div_code == CDGC_DIV_TOP) ? CDGC_DIV_CLAMP
		: div_code;
	assign wrap       = (cnt_reg >= last_count);
	assign cnt_next   = wrap ? '0 : cnt_reg + 1'b1;

	// ****************************************************************
	// counter
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick    <= wrap;
		end
	end

endmodule : cdgc_divider

`default_nettype wire

// file: src/cdgc_top.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module cdgc_top
	import cdgc_pkg::*;
(
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output var  logic                     hreadyout,
	output var  logic                     hresp,
	output var  logic [31:0]              hrdata,
	input  wire logic [CDGC_CHANNELS-1:0] module_filter_enable,
	input  wire logic                     cal_done,
	output var  logic [CDGC_CHANNELS-1:0] sinc_enable,
	output var  logic                     gen_high_drive_select,
	output var  logic                     generator_enable_bit,
	output var  logic                     calibration_start_status,
	output var  logic [1:0]               calibration_channel_select,
	output var  logic [CDGC_CHANNELS-1:0] cal_module_onehot,
	output var  logic [CDGC_CHANNELS-1:0] demod_module_onehot,
	output var  logic                     cal_start_pulse,
	output var  logic                     mod_clk_tick,
	output var  logic                     gen_clk_tick,
	output var  logic                     generator_output_a,
	output var  logic                     generator_output_b
);

	// ****************************************************************
	// bus address phase
	// ****************************************************************
	cdgc_xfer_t            xfer_reg;
	cdgc_xfer_t            xfer_next;
	logic                  addr_take;
	logic                  wr_cfg;
	logic                  wr_pat;
	logic [CDGC_REG_W-1:0] wdata16;

	assign addr_take = hsel && hready && htrans[1];
	assign xfer_next = '{valid: addr_take, write: hwrite,
		addr: haddr[CDGC_ADDR_W-1:0]};

	// writes land in the data phase, when hwdata stands
	assign wdata16 = hwdata[CDGC_REG_W-1:0];
	assign wr_cfg  = xfer_reg.valid && xfer_reg.write
		&& (xfer_reg.addr == CDGC_ADDR_CLKDIV);
	assign wr_pat  = xfer_reg.valid && xfer_reg.write
		&& (xfer_reg.addr == CDGC_ADDR_PATTERN);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xfer_reg <= '0;
		end else if (hready) begin
			xfer_reg <= xfer_next;
		end
	end

	// ****************************************************************
	// configuration register
	// ****************************************************************
	cdgc_cfg_t cfg_reg;
	cdgc_cfg_t cfg_next;
	logic      busy_reg;
	logic      busy_next;
	logic      start_req;

	// bits 15 to 13 are dropped, bit 9 feeds the busy flag instead
	assign cfg_next = wr_cfg
		? cdgc_cfg_t'({wdata16[CDGC_HBE_BIT:CDGC_SGE_BIT],
			wdata16[CDGC_CAL_BIT-1:CDGC_GEN_LSB]})
		: cfg_reg;

	assign start_req = wr_cfg && wdata16[CDGC_CAL_BIT];
	// a start in the finishing cycle wins over the finish
	assign busy_next = start_req ? 1'b1
		: (cal_done ? 1'b0 : busy_reg);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg  <= cdgc_cfg_t'({CDGC_CFG_RESET[CDGC_HBE_BIT:CDGC_SGE_BIT],
				CDGC_CFG_RESET[CDGC_CAL_BIT-1:CDGC_GEN_LSB]});
			busy_reg <= 1'b0;
		end else begin
			cfg_reg  <= cfg_next;
			busy_reg <= busy_next;
		end
	end

	// ****************************************************************
	// pattern shift register
	// ****************************************************************
	logic [CDGC_PAT_W-1:0] pat_reg;
	logic [CDGC_PAT_W-1:0] pat_next;
	logic [CDGC_PAT_W-1:0] pat_rot;
	logic                  gen_tick_w;

	assign pat_rot  = {pat_reg[CDGC_PAT_W-2:0], pat_reg[CDGC_PAT_W-1]};
	assign pat_next = wr_pat
		? {pat_reg[CDGC_PAT_W-CDGC_PAT_STEP-1:0], wdata16}
		: ((cfg_reg.gen_enable && gen_tick_w) ? pat_rot : pat_reg);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pat_reg <= '0;
		end else begin
			pat_reg <= pat_next;
		end
	end

	// ****************************************************************
	// clock dividers
	// ****************************************************************
	logic                  mod_tick_w;
	logic [CDGC_DIV_W-1:0] mod_code;

	assign mod_code = {1'b0, cfg_reg.mod_div};

	cdgc_divider u_gen_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.div_code (cfg_reg.gen_div),
		.tick     (gen_tick_w)
	);

	cdgc_divider u_mod_div (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.div_code (mod_code),
		.tick     (mod_tick_w)
	);

	// ****************************************************************
	// read data
	// ****************************************************************
	logic [CDGC_REG_W-1:0] cfg_view;
	logic [CDGC_REG_W-1:0] status_view;
	logic [CDGC_REG_W-1:0] rd_mux;
	logic                  rd_take;
	logic [CDGC_CHANNELS-1:0] sinc_next;

	// read mux sees the pending write so back-to-back access is coherent
	assign cfg_view = {3'b000, cfg_next.high_drive, cfg_next.master_gate,
		cfg_next.gen_enable, busy_next, cfg_next.channel,
		cfg_next.mod_div, cfg_next.gen_div};

	always_comb begin
		status_view = '0;
		status_view[CDGC_ST_BUSY_BIT] = busy_next;
		status_view[CDGC_ST_SINC_LSB +: CDGC_CHANNELS] = sinc_next;
	end

	assign rd_take = addr_take && !hwrite;
	assign rd_mux  = (haddr[CDGC_ADDR_W-1:0] == CDGC_ADDR_CLKDIV) ? cfg_view
		: (haddr[CDGC_ADDR_W-1:0] == CDGC_ADDR_STATUS) ? status_view
		: '0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= rd_take ? {16'h0000, rd_mux} : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// ****************************************************************
	// per-module filter gating and channel selection
	// ****************************************************************
	logic [CDGC_CHANNELS-1:0] onehot_next;

	genvar ch;
	generate
		for (ch = 0; ch < CDGC_CHANNELS; ch++) begin : g_chan
			assign sinc_next[ch] = cfg_next.master_gate
				&& module_filter_enable[ch];
			assign onehot_next[ch] = (cfg_next.channel == 2'(ch));
		end
	endgenerate

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sinc_enable                <= '0;
			gen_high_drive_select      <= 1'b0;
			generator_enable_bit       <= 1'b0;
			calibration_start_status   <= 1'b0;
			calibration_channel_select <= 2'b00;
			cal_module_onehot          <= '0;
			demod_module_onehot        <= '0;
			cal_start_pulse            <= 1'b0;
			mod_clk_tick               <= 1'b0;
			gen_clk_tick               <= 1'b0;
			generator_output_a         <= 1'b0;
			generator_output_b         <= 1'b0;
		end else begin
			sinc_enable                <= sinc_next;
			gen_high_drive_select      <= cfg_next.high_drive;
			generator_enable_bit       <= cfg_next.gen_enable;
			calibration_start_status   <= busy_next;
			calibration_channel_select <= cfg_next.channel;
			cal_module_onehot          <= busy_next ? onehot_next : '0;
			demod_module_onehot        <= onehot_next;
			cal_start_pulse            <= start_req;
			mod_clk_tick               <= mod_tick_w;
			gen_clk_tick               <= gen_tick_w && cfg_reg.gen_enable;
			// generator pins idle low while disabled
			generator_output_a <= cfg_reg.gen_enable
				&& pat_reg[CDGC_PAT_W-1];
			generator_output_b <= cfg_reg.gen_enable
				&& !pat_reg[CDGC_PAT_W-1];
		end
	end

endmodule : cdgc_top

`default_nettype wire

// file: dv/cdgc_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module cdgc_checker
	import cdgc_pkg::*;
(
	input wire logic                     hclk,
	input wire logic                     hresetn,
	input wire logic                     hreadyout,
	input wire logic                     hresp,
	input wire logic [31:0]              hrdata,
	input wire logic [CDGC_CHANNELS-1:0] module_filter_enable,
	input wire logic                     cal_done,
	input wire logic [CDGC_CHANNELS-1:0] sinc_enable,
	input wire logic                     generator_enable_bit,
	input wire logic                     calibration_start_status,
	input wire logic [1:0]               calibration_channel_select,
	input wire logic [CDGC_CHANNELS-1:0] cal_module_onehot,
	input wire logic [CDGC_CHANNELS-1:0] demod_module_onehot,
	input wire logic                     cal_start_pulse,
	input wire logic                     gen_clk_tick,
	input wire logic                     generator_output_a,
	input wire logic                     generator_output_b
);
	// ****************************************************************
	// port relations
	// ****************************************************************
	logic settled_reg;

	// outputs hold their reset values until the first edge after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settled_reg <= 1'b0;
		end else begin
			settled_reg <= 1'b1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	upper_zero_a: assert property (hrdata[31:13] == 19'h0)
		else $error("read data upper bits not zero");
	sinc_gate_a: assert property (
		(sinc_enable & ~$past(module_filter_enable)) == 4'h0)
		else $error("sinc unit on without its own enable");
	demod_sel_a: assert property (settled_reg |->
		demod_module_onehot == (4'h1 << calibration_channel_select))
		else $error("demodulation module does not follow select");
	cal_sel_a: assert property (cal_module_onehot ==
		(calibration_start_status ? 4'h1 << calibration_channel_select : 4'h0))
		else $error("calibration module does not follow select");
	gen_off_a: assert property (!generator_enable_bit [*2] |->
		!gen_clk_tick && !generator_output_a && !generator_output_b)
		else $error("generator active while disabled");
	gen_comp_a: assert property (generator_enable_bit [*2] |->
		generator_output_b == !generator_output_a)
		else $error("generator outputs not complementary");
	cal_start_a: assert property (
		cal_start_pulse |-> ##[0:1] calibration_start_status)
		else $error("start pulse without busy status");
	cal_end_a: assert property (calibration_start_status && cal_done |=>
		!calibration_start_status || cal_start_pulse)
		else $error("busy status not cleared on finish");

	cover property ($rose(calibration_start_status));
	cover property ($fell(calibration_start_status));
	cover property (gen_clk_tick && generator_output_a);
endmodule : cdgc_checker

bind cdgc_top cdgc_checker cdgc_checker_i (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.module_filter_enable(module_filter_enable), .cal_done(cal_done),
	.sinc_enable(sinc_enable), .generator_enable_bit(generator_enable_bit),
	.calibration_start_status(calibration_start_status),
	.calibration_channel_select(calibration_channel_select),
	.cal_module_onehot(cal_module_onehot),
	.demod_module_onehot(demod_module_onehot),
	.cal_start_pulse(cal_start_pulse), .gen_clk_tick(gen_clk_tick),
	.generator_output_a(generator_output_a),
	.generator_output_b(generator_output_b));

`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
	import cdgc_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        cal_done = 1'b0, hreadyout, hresp, hd, ge, cs, pulse;
	logic        mt, gt, oa, ob;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0, ch;
	logic [2:0]  hsize = CDGC_HSIZE_WORD;
	logic [3:0]  fen_in = 4'h0, sinc, cal_oh, dem_oh;
	int          bad_count = 0, checks_done = 0, n, hi;
	logic [15:0] cfg_r[6] = '{16'hE400, 16'h0471, 16'h148E, 16'h0D3F,
		16'h0595, 16'h1803};
	int          gp[6] = '{1, 2, 15, 15, 6, 40};
	int          mp[6] = '{1, 8, 1, 4, 2, 1};

	always #10 hclk = ~hclk;

	cdgc_top cdgc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .module_filter_enable(fen_in),
		.cal_done(cal_done), .sinc_enable(sinc), .gen_high_drive_select(hd),
		.generator_enable_bit(ge), .calibration_start_status(cs),
		.calibration_channel_select(ch), .cal_module_onehot(cal_oh),
		.demod_module_onehot(dem_oh), .cal_start_pulse(pulse),
		.mod_clk_tick(mt), .gen_clk_tick(gt), .generator_output_a(oa),
		.generator_output_b(ob));

	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// called just after a rising edge; returns on the data-phase edge
	task bus(input logic w, input logic [9:0] a, input logic [15:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		hwrite <= w;
		htrans <= CDGC_HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {16'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	// cycles between two ticks, 40 when no tick comes
	task period(input logic which);
		n = 0;
		do begin @(negedge hclk); n++; end
		while ((which ? gt : mt) !== 1'b1 && n < 40);
		n = 0;
		do begin @(negedge hclk); n++; end
		while ((which ? gt : mt) !== 1'b1 && n < 40);
		@(posedge hclk);
	endtask : period

	initial begin
		#200000;
		bad_count++;
		complete_run();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (3) @(posedge hclk);
		#1;
		chk("ready", hreadyout, 32'h1);
		chk("outs", {sinc, hd, ge, cs, ch, cal_oh, pulse, oa, ob}, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
		chk("cfg reset", rd, 32'h0);
		fen_in <= 4'hA;
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, CDGC_ADDR_CLKDIV, cfg_r[i]);
			bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
			chk("cfg", rd, {16'h0, cfg_r[i] & 16'h1FFF});
			chk("drive", hd, cfg_r[i][12]);
			chk("gen en", ge, cfg_r[i][10]);
			chk("sinc", sinc, cfg_r[i][11] ? 4'hA : 4'h0);
			chk("chan", ch, cfg_r[i][8:7]);
			chk("demod", dem_oh, 4'h1 << cfg_r[i][8:7]);
			bus(1'b0, CDGC_ADDR_STATUS, 16'h0);
			chk("status", rd, cfg_r[i][11] ? 32'hA0 : 32'h0);
			period(1'b1);
			chk("gen div", n, gp[i]);
			period(1'b0);
			chk("mod div", n, mp[i]);
		end
		chk("gen idle", {oa, ob}, 32'h0);
		repeat (3) bus(1'b1, CDGC_ADDR_PATTERN, 16'hFFFF);
		bus(1'b1, CDGC_ADDR_PATTERN, 16'h0001);
		bus(1'b0, CDGC_ADDR_PATTERN, 16'h0);
		chk("pat read", rd, 32'h0);
		bus(1'b1, CDGC_ADDR_CLKDIV, 16'h040F);
		repeat (3) @(posedge hclk);
		hi = 0;
		repeat (960) begin @(negedge hclk); hi += int'(oa === 1'b1); end
		chk("pattern", hi, 735);
		@(posedge hclk);
		bus(1'b1, CDGC_ADDR_CLKDIV, 16'h0700);
		@(negedge hclk);
		chk("start pulse", pulse, 32'h1);
		@(posedge hclk);
		bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
		chk("busy", rd, 32'h0700);
		chk("pulse end", pulse, 32'h0);
		chk("cal mod", cal_oh, 4'h4);
		bus(1'b0, CDGC_ADDR_STATUS, 16'h0);
		chk("status busy", rd, 32'h0001);
		cal_done <= 1'b1;
		@(posedge hclk);
		cal_done <= 1'b0;
		@(posedge hclk);
		bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
		chk("cal end", rd, 32'h0500);
		chk("cal off", cal_oh, 4'h0);
		bus(1'b0, CDGC_ADDR_STATUS, 16'h0);
		chk("status idle", rd, 32'h0);
		cal_done <= 1'b1;
		bus(1'b1, CDGC_ADDR_CLKDIV, 16'h0200);
		cal_done <= 1'b0;
		bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
		chk("start wins", rd, 32'h0200);
		bus(1'b0, 10'h3FC, 16'h0);
		chk("unmapped", rd, 32'h0);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, CDGC_ADDR_CLKDIV, 16'h0);
		chk("cfg rerst", rd, 32'h0);
		complete_run();
	end
endmodule : testbench

`default_nettype wire
